// File: logic/dsr_pkg.sv
// constants and types of the double-rate burst-of-two static memory interface
package dsr_pkg;
    localparam int ADDR_W = 8;
    localparam int WORD_W = 18;
    localparam int LANE_W = 2;
    localparam int LANE_BITS = 9;
    localparam int DEPTH = 256;
    localparam int DLL_LOCK_CYCLES = 1024;
    localparam int ZQ_CAL_CYCLES = 1024;
    localparam int CLK_PERIOD_NS = 8;
    localparam int DLL_STOP_NS = 30;
    localparam int DLL_STOP_CYCLES = (DLL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [10:0] LOCK_MAX = 11'(DLL_LOCK_CYCLES);
    localparam logic [10:0] CAL_MAX = 11'(ZQ_CAL_CYCLES - 1);
    localparam logic [3:0] STOP_MAX = 4'(DLL_STOP_CYCLES);
    typedef enum {DSR_IDLE, DSR_RD, DSR_WR} dsr_cmd_t;
endpackage

// File: logic/dsr_sync.sv
// two flip-flop level synchroniser
module dsr_sync (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic din,
    output logic dout
);
    logic meta_r;
    logic sync_r;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end
    assign dout = sync_r;
endmodule

// File: logic/dsr_outstage.sv
// read data and echo strobe output registers on the output clock
module dsr_outstage (
    input wire logic outClk,
    input wire logic rst_b,
    input wire logic [dsr_pkg::WORD_W-1:0] wordIn,
    input wire logic wordValid,
    output logic [dsr_pkg::WORD_W-1:0] readBusOut,
    output logic readBusOe,
    output logic echoStrobe,
    output logic echoStrobeN
);
    import dsr_pkg::*;
    logic [WORD_W-1:0] data_r, data_nxt;
    logic oe_r, oe_nxt;
    logic echo_r, echo_nxt;
    logic echoN_r, echoN_nxt;
    always_comb begin
        data_nxt = wordValid ? wordIn : data_r;
        oe_nxt = wordValid;
        echo_nxt = ~echo_r;
        echoN_nxt = echo_r;
    end
    always_ff @(posedge outClk or negedge rst_b) begin
        if (!rst_b) begin
            data_r <= '0;
            oe_r <= 1'b0;
            echo_r <= 1'b0;
            echoN_r <= 1'b1;
        end else begin
            data_r <= data_nxt;
            oe_r <= oe_nxt;
            echo_r <= echo_nxt;
            echoN_r <= echoN_nxt;
        end
    end
    assign readBusOut = data_r;
    assign readBusOe = oe_r;
    assign echoStrobe = echo_r;
    assign echoStrobeN = echoN_r;
endmodule

// File: logic/dsr_core.sv
// command, write, posted write and array logic of the burst-of-two memory
module dsr_core (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic kClk,
    input wire logic outClkX2,
    input wire logic outStrapHi,
    input wire logic dllDisableN,
    input wire logic dirSelect,
    input wire logic loadStrobeN,
    input wire logic [dsr_pkg::ADDR_W-1:0] addrIn,
    input wire logic [dsr_pkg::WORD_W-1:0] writeBusIn,
    input wire logic [dsr_pkg::LANE_W-1:0] laneWriteMaskN,
    output logic [dsr_pkg::WORD_W-1:0] readBusOut,
    output logic readBusOe,
    output logic echoStrobe,
    output logic echoStrobeN,
    output logic dllLocked_r,
    output logic zqCalPulse_r,
    output logic singleClock_r
);
    import dsr_pkg::*;
    // clock oversamples kClk, 4 or 16 clock cycles per k period in the bench; kClk phase tells positive rise
    logic kSync;
    logic kPrev_r, kPrev_nxt;
    logic posRise, negRise;
    dsr_sync uKSync (
        .clock(clock),
        .rst_b(rst_b),
        .din(kClk),
        .dout(kSync)
    );
    assign posRise = kSync & ~kPrev_r;
    assign negRise = ~kSync & kPrev_r;

    // strap capture after reset release
    logic strapSync;
    logic [2:0] strapDone_r, strapDone_nxt;
    logic single_nxt;
    dsr_sync uStrap (
        .clock(clock),
        .rst_b(rst_b),
        .din(outStrapHi),
        .dout(strapSync)
    );

    logic dllSync;
    dsr_sync uDll (
        .clock(clock),
        .rst_b(rst_b),
        .din(dllDisableN),
        .dout(dllSync)
    );

    // command, address and data pins pass two flops, in step with kSync
    localparam int PIN_W = 2 + ADDR_W + WORD_W + LANE_W;
    logic [PIN_W-1:0] pinRaw, pinSync;
    logic dirSync, loadSyncN;
    logic [ADDR_W-1:0] addrSync;
    logic [WORD_W-1:0] wdataSync;
    logic [LANE_W-1:0] maskSyncN;
    assign pinRaw = {dirSelect, loadStrobeN, addrIn, writeBusIn, laneWriteMaskN};
    for (genvar g = 0; g < PIN_W; g++) begin : gPinSync
        dsr_sync uPin (
            .clock(clock),
            .rst_b(rst_b),
            .din(pinRaw[g]),
            .dout(pinSync[g])
        );
    end
    assign {dirSync, loadSyncN, addrSync, wdataSync, maskSyncN} = pinSync;

    logic [WORD_W-1:0] mem_r [DEPTH];
    logic [WORD_W-1:0] memNxt [DEPTH];
    dsr_cmd_t cmd_r, cmd_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [WORD_W-1:0] wd0_r, wd0_nxt, wd1_r, wd1_nxt;
    logic [LANE_W-1:0] wm0_r, wm0_nxt, wm1_r, wm1_nxt;
    logic postValid_r, postValid_nxt;
    logic [ADDR_W-1:0] postAddr_r, postAddr_nxt;
    logic [WORD_W-1:0] postD0_r, postD0_nxt, postD1_r, postD1_nxt;
    logic [LANE_W-1:0] postM0_r, postM0_nxt, postM1_r, postM1_nxt;
    logic [WORD_W-1:0] rdWord_r, rdWord_nxt;
    logic rdValid_r, rdValid_nxt;
    logic [WORD_W-1:0] rdHold_r, rdHold_nxt;
    logic rdHoldV_r, rdHoldV_nxt;
    logic [10:0] lockCnt_r, lockCnt_nxt;
    logic [10:0] calCnt_r, calCnt_nxt;
    logic [3:0] stopCnt_r, stopCnt_nxt;
    logic lock_nxt, cal_nxt;

    function automatic logic [WORD_W-1:0] laneMerge(input logic [WORD_W-1:0] old,
                                                    input logic [WORD_W-1:0] nw,
                                                    input logic [LANE_W-1:0] mN);
        logic [WORD_W-1:0] r;
        r = old;
        for (int i = 0; i < LANE_W; i++) begin
            if (!mN[i]) begin
                r[i*LANE_BITS +: LANE_BITS] = nw[i*LANE_BITS +: LANE_BITS];
            end
        end
        return r;
    endfunction

    function automatic logic [ADDR_W-1:0] burstAddr(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:1], ~a[0]};
    endfunction

    // newest view of one word including posted write
    function automatic logic [WORD_W-1:0] fetch(input logic [WORD_W-1:0] arr,
                                                input logic [ADDR_W-1:0] a,
                                                input logic pv,
                                                input logic [ADDR_W-1:0] pa,
                                                input logic [WORD_W-1:0] p0,
                                                input logic [WORD_W-1:0] p1,
                                                input logic [LANE_W-1:0] m0,
                                                input logic [LANE_W-1:0] m1);
        logic [WORD_W-1:0] r;
        r = arr;
        if (pv && a == pa) begin
            r = laneMerge(arr, p0, m0);
        end else if (pv && a == burstAddr(pa)) begin
            r = laneMerge(arr, p1, m1);
        end
        return r;
    endfunction

    always_comb begin
        kPrev_nxt = kSync;
        strapDone_nxt = {strapDone_r[1:0], 1'b1}; // strap read once its synchroniser is full
        single_nxt = strapDone_r[2] ? singleClock_r : strapSync;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        phase_nxt = phase_r;
        wd0_nxt = wd0_r;
        wd1_nxt = wd1_r;
        wm0_nxt = wm0_r;
        wm1_nxt = wm1_r;
        postValid_nxt = postValid_r;
        postAddr_nxt = postAddr_r;
        postD0_nxt = postD0_r;
        postD1_nxt = postD1_r;
        postM0_nxt = postM0_r;
        postM1_nxt = postM1_r;
        rdWord_nxt = rdWord_r;
        rdValid_nxt = rdValid_r;
        rdHold_nxt = rdHold_r;
        rdHoldV_nxt = rdHoldV_r;
        memNxt = mem_r;
        if (posRise) begin
            // word0 launches here, word1 at the following complementary rise
            rdValid_nxt = 1'b0;
            rdHoldV_nxt = 1'b0;
            if (cmd_r == DSR_WR && phase_r == 2'd2) begin
                // completed write pair becomes the posted write
                if (postValid_r) begin
                    memNxt[postAddr_r] = laneMerge(mem_r[postAddr_r], postD0_r, postM0_r);
                    memNxt[burstAddr(postAddr_r)] =
                        laneMerge(mem_r[burstAddr(postAddr_r)], postD1_r, postM1_r);
                end
                postValid_nxt = 1'b1;
                postAddr_nxt = addr_r;
                postD0_nxt = wd0_r;
                postD1_nxt = wd1_r;
                postM0_nxt = wm0_r;
                postM1_nxt = wm1_r;
            end
            if (cmd_r == DSR_RD) begin
                rdWord_nxt = fetch(mem_r[addr_r], addr_r, postValid_r, postAddr_r,
                                   postD0_r, postD1_r, postM0_r, postM1_r);
                rdValid_nxt = 1'b1;
                rdHold_nxt = fetch(mem_r[burstAddr(addr_r)], burstAddr(addr_r), postValid_r,
                                   postAddr_r, postD0_r, postD1_r, postM0_r, postM1_r);
                rdHoldV_nxt = 1'b1;
            end
            if (cmd_r == DSR_WR && phase_r == 2'd0) begin
                wd0_nxt = wdataSync;
                wm0_nxt = maskSyncN;
                phase_nxt = 2'd1;
            end else if (!loadSyncN) begin
                cmd_nxt = dirSync ? DSR_RD : DSR_WR;
                addr_nxt = addrSync;
                phase_nxt = 2'd0;
            end else begin
                cmd_nxt = DSR_IDLE;
                phase_nxt = 2'd0;
            end
        end else if (negRise) begin
            if (rdHoldV_r) begin
                rdWord_nxt = rdHold_r;
                rdHoldV_nxt = 1'b0;
            end
            if (cmd_r == DSR_WR && phase_r == 2'd1) begin
                wd1_nxt = wdataSync;
                wm1_nxt = maskSyncN;
                phase_nxt = 2'd2;
            end
        end
    end

    always_comb begin
        lockCnt_nxt = lockCnt_r;
        stopCnt_nxt = stopCnt_r;
        calCnt_nxt = (calCnt_r == CAL_MAX) ? '0 : calCnt_r + 11'd1;
        cal_nxt = (calCnt_r == CAL_MAX);
        if (posRise) begin
            stopCnt_nxt = '0;
            if (lockCnt_r != LOCK_MAX) begin
                lockCnt_nxt = lockCnt_r + 11'd1;
            end
        end else if (stopCnt_r == STOP_MAX) begin
            lockCnt_nxt = '0;
        end else begin
            stopCnt_nxt = stopCnt_r + 4'd1;
        end
        lock_nxt = dllSync && (lockCnt_nxt == LOCK_MAX);
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            kPrev_r <= 1'b0;
            strapDone_r <= '0;
            singleClock_r <= 1'b0;
            cmd_r <= DSR_IDLE;
            addr_r <= '0;
            phase_r <= '0;
            wd0_r <= '0;
            wd1_r <= '0;
            wm0_r <= '1;
            wm1_r <= '1;
            postValid_r <= 1'b0;
            postAddr_r <= '0;
            postD0_r <= '0;
            postD1_r <= '0;
            postM0_r <= '1;
            postM1_r <= '1;
            rdWord_r <= '0;
            rdValid_r <= 1'b0;
            rdHold_r <= '0;
            rdHoldV_r <= 1'b0;
            lockCnt_r <= '0;
            calCnt_r <= '0;
            stopCnt_r <= '0;
            dllLocked_r <= 1'b0;
            zqCalPulse_r <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            kPrev_r <= kPrev_nxt;
            strapDone_r <= strapDone_nxt;
            singleClock_r <= single_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            phase_r <= phase_nxt;
            wd0_r <= wd0_nxt;
            wd1_r <= wd1_nxt;
            wm0_r <= wm0_nxt;
            wm1_r <= wm1_nxt;
            postValid_r <= postValid_nxt;
            postAddr_r <= postAddr_nxt;
            postD0_r <= postD0_nxt;
            postD1_r <= postD1_nxt;
            postM0_r <= postM0_nxt;
            postM1_r <= postM1_nxt;
            rdWord_r <= rdWord_nxt;
            rdValid_r <= rdValid_nxt;
            rdHold_r <= rdHold_nxt;
            rdHoldV_r <= rdHoldV_nxt;
            lockCnt_r <= lockCnt_nxt;
            calCnt_r <= calCnt_nxt;
            stopCnt_r <= stopCnt_nxt;
            dllLocked_r <= lock_nxt;
            zqCalPulse_r <= cal_nxt;
            mem_r <= memNxt;
        end
    end

    // read words cross to the output clock; each stands half a k cycle, one output slot
    logic [WORD_W-1:0] xWord1_r, xWord2_r;
    logic xV1_r, xV2_r;
    always_ff @(posedge outClkX2 or negedge rst_b) begin
        if (!rst_b) begin
            xWord1_r <= '0;
            xWord2_r <= '0;
            xV1_r <= 1'b0;
            xV2_r <= 1'b0;
        end else begin
            xWord1_r <= rdWord_r;
            xV1_r <= rdValid_r;
            xWord2_r <= xWord1_r;
            xV2_r <= xV1_r;
        end
    end
    dsr_outstage uOut (
        .outClk(outClkX2),
        .rst_b(rst_b),
        .wordIn(xWord2_r),
        .wordValid(xV2_r),
        .readBusOut(readBusOut),
        .readBusOe(readBusOe),
        .echoStrobe(echoStrobe),
        .echoStrobeN(echoStrobeN)
    );
    // in single clock mode the bench still feeds outClkX2 from its own free-running clock
endmodule

// File: dv/dsr_ctl_model.sv
// controller model driving the input clock, commands and write data
module dsr_ctl_model (
    input wire logic clock,
    input wire logic fast,
    input wire logic hold,
    output logic kClk = 1'h0,
    output logic dirSelect = 1'h0,
    output logic loadStrobeN = 1'h1,
    output logic [dsr_pkg::ADDR_W-1:0] addrIn = 8'h0,
    output logic [dsr_pkg::WORD_W-1:0] writeBusIn = 18'h0,
    output logic [dsr_pkg::LANE_W-1:0] laneWriteMaskN = 2'h3
);
    import dsr_pkg::*;
    int ph = 0;
    wire logic edgeNow = !hold && ph >= (fast ? 1 : 7);
    always @(posedge clock) begin
        if (edgeNow) begin
            ph <= 0;
            kClk <= !kClk;
        end else if (!hold) begin
            ph <= ph + 1;
        end
    end
    task automatic waitEdge(input logic lvl);
        do begin
            @(posedge clock);
        end while (!(edgeNow && kClk == lvl));
    endtask
    // whole commands only, a burst is never cut short
    task automatic issue(input dsr_cmd_t op, input logic [ADDR_W-1:0] a,
        input logic [WORD_W-1:0] w0, input logic [WORD_W-1:0] w1,
        input logic [LANE_W-1:0] m0, input logic [LANE_W-1:0] m1);
        waitEdge(1'h0);
        loadStrobeN <= (op == DSR_IDLE);
        dirSelect <= (op == DSR_RD);
        addrIn <= (op == DSR_IDLE) ? ~addrIn : a;
        writeBusIn <= ~writeBusIn;
        if (op == DSR_WR) begin
            waitEdge(1'h0);
            loadStrobeN <= 1'h1;
            addrIn <= ~a;
            writeBusIn <= w0;
            laneWriteMaskN <= m0;
            waitEdge(1'h1);
            writeBusIn <= w1;
            laneWriteMaskN <= m1;
        end
    endtask
endmodule

// File: dv/dsr_core_asserts.sv
// concurrent checks on the ports of the burst-of-two memory core
module dsr_core_asserts (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic kClk,
    input wire logic outClkX2,
    input wire logic dllDisableN,
    input wire logic loadStrobeN,
    input wire logic readBusOe,
    input wire logic echoStrobe,
    input wire logic echoStrobeN,
    input wire logic dllLocked_r,
    input wire logic zqCalPulse_r,
    input wire logic singleClock_r
);
    logic [10:0] zqCnt_r, zqCnt_nxt, rises_r, rises_nxt;
    logic [3:0] still_r, still_nxt;
    logic [6:0] idle_r, idle_nxt;
    logic kPrev_r;
    always_comb begin
        zqCnt_nxt = zqCalPulse_r ? 11'h1 : zqCnt_r + {10'h0, |zqCnt_r && !(&zqCnt_r)};
        still_nxt = (kClk != kPrev_r) ? 4'h0 : still_r + {3'h0, !(&still_r)};
        rises_nxt = (still_r > 4'h4) ? 11'h0 : rises_r + {10'h0, kClk && !kPrev_r && !(&rises_r)};
        idle_nxt = loadStrobeN ? idle_r + {6'h0, !(&idle_r)} : 7'h0;
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            zqCnt_r <= 11'h0;
            rises_r <= 11'h0;
            still_r <= 4'h0;
            idle_r <= 7'h0;
            kPrev_r <= 1'h0;
        end else begin
            zqCnt_r <= zqCnt_nxt;
            rises_r <= rises_nxt;
            still_r <= still_nxt;
            idle_r <= idle_nxt;
            kPrev_r <= kClk;
        end
    end
    sequence s_pair;
        readBusOe [*2];
    endsequence
    chk_reset_quiet: assert property (@(posedge clock) !rst_b |-> !readBusOe && !dllLocked_r)
        else $error("outputs active in reset");
    chk_echo_compl: assert property (@(posedge outClkX2) disable iff (!rst_b)
        $past(rst_b, 2) |-> echoStrobeN != echoStrobe) else $error("echo strobes equal");
    chk_echo_toggle: assert property (@(posedge outClkX2) disable iff (!rst_b)
        $past(rst_b, 2) |-> echoStrobe != $past(echoStrobe)) else $error("echo strobe stuck");
    chk_burst_pair: assert property (@(posedge outClkX2) disable iff (!rst_b)
        $rose(readBusOe) |-> s_pair) else $error("read burst shorter than two words");
    chk_idle_release: assert property (@(posedge clock) disable iff (!rst_b)
        idle_r > 7'h5F |-> !readBusOe) else $error("bus driven while idle");
    chk_zq_period: assert property (@(posedge clock) disable iff (!rst_b)
        zqCalPulse_r && |zqCnt_r |-> zqCnt_r == 11'h400) else $error("calibration period wrong");
    chk_zq_missing: assert property (@(posedge clock) disable iff (!rst_b)
        |zqCnt_r |-> zqCnt_r <= 11'h400) else $error("calibration pulse missing");
    chk_lock_gate: assert property (@(posedge clock) disable iff (!rst_b)
        !dllDisableN && !$past(dllDisableN) |-> !dllLocked_r) else $error("lock with dll off");
    chk_lock_count: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(dllLocked_r) |-> rises_r >= 11'h400) else $error("lock too early");
    chk_stop_unlock: assert property (@(posedge clock) disable iff (!rst_b)
        still_r == 4'h5 |-> ##[0:4] !dllLocked_r) else $error("lock kept with clock stopped");
    chk_strap_hold: assert property (@(posedge clock) disable iff (!rst_b)
        $past(rst_b, 4) |-> $stable(singleClock_r)) else $error("strap changed in operation");
endmodule
bind dsr_core dsr_core_asserts chk (.clock(clock), .rst_b(rst_b), .kClk(kClk),
    .outClkX2(outClkX2), .dllDisableN(dllDisableN), .loadStrobeN(loadStrobeN),
    .readBusOe(readBusOe), .echoStrobe(echoStrobe), .echoStrobeN(echoStrobeN),
    .dllLocked_r(dllLocked_r), .zqCalPulse_r(zqCalPulse_r), .singleClock_r(singleClock_r));

// File: dv/tb_top.sv
// self-checking bench of the burst-of-two memory core
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dsr_pkg::*;
    logic clock = 1'h0;
    logic outClkX2 = 1'h0;
    logic rst_b = 1'h1;
    logic outStrapHi = 1'h0;
    logic dllDisableN = 1'h0;
    logic fast = 1'h0;
    logic hold = 1'h0;
    logic kClk, dirSelect, loadStrobeN, readBusOe, echoStrobe, echoStrobeN;
    logic dllLocked_r, zqCalPulse_r, singleClock_r;
    logic [ADDR_W-1:0] addrIn;
    logic [WORD_W-1:0] writeBusIn, readBusOut;
    logic [LANE_W-1:0] laneWriteMaskN;
    logic [WORD_W-1:0] mem [DEPTH];
    logic [WORD_W-1:0] expQ [$];
    logic [ADDR_W-1:0] adr [8];
    logic [31:0] seed = 32'h16EE2;
    int fails = 0;
    int tests_run = 0;
    dsr_ctl_model ctl (.*);
    dsr_core DUT (.*);
    initial begin
        forever #4 clock = ~clock;
    end
    initial begin
        #3;
        forever #32 outClkX2 = ~outClkX2;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o,
        input logic [WORD_W-1:0] n, input logic [LANE_W-1:0] mN);
        merge = o;
        if (!mN[0]) merge[8:0] = n[8:0];
        if (!mN[1]) merge[17:9] = n[17:9];
    endfunction
    task automatic cmp(input string nm, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cmpBit(input string nm, input logic e, input logic s);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic doReset(input logic strap);
        rst_b <= 1'h0;
        outStrapHi <= strap;
        repeat (16) @(posedge clock);
        rst_b <= 1'h1;
        repeat (4) @(posedge clock);
        cmpBit("singleClock_r", strap, singleClock_r);
        cmpBit("readBusOe", 1'h0, readBusOe);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        expQ.push_back(mem[a]);
        expQ.push_back(mem[a ^ 8'h01]);
        ctl.issue(DSR_RD, a, 18'h0, 18'h0, 2'h3, 2'h3);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANE_W-1:0] m0,
        input logic [LANE_W-1:0] m1);
        logic [WORD_W-1:0] d0, d1;
        d0 = 18'(rnd());
        d1 = 18'(rnd());
        mem[a] = merge(mem[a], d0, m0);
        mem[a ^ 8'h01] = merge(mem[a ^ 8'h01], d1, m1);
        ctl.issue(DSR_WR, a, d0, d1, m0, m1);
    endtask
    always @(negedge outClkX2) begin
        if (readBusOe === 1'h1 && expQ.size() == 0) begin
            cmpBit("readBusOe", 1'h0, readBusOe);
        end else if (readBusOe === 1'h1) begin
            cmp("readBusOut", expQ.pop_front(), readBusOut);
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        stop_test();
    end
    initial begin
        doReset(1'h1);
        doReset(1'h0);
        for (int i = 0; i < 8; i++) begin
            adr[i] = 8'(rnd());
            wr(adr[i], 2'h0, 2'h0);
        end
        for (int i = 0; i < 16; i++) begin
            wr(adr[i % 8], 2'(i), 2'(i >> 2));
            rd(adr[i % 8]);
            ctl.issue(DSR_IDLE, 8'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        end
        for (int i = 7; i >= 0; i--) rd(adr[i]);
        ctl.issue(DSR_IDLE, 8'h0, 18'h0, 18'h0, 2'h3, 2'h3);
        repeat (100) @(posedge clock);
        cmpBit("readBusOe", 1'h0, readBusOe);
        cmp("pending words", 18'h0, 18'(expQ.size()));
        dllDisableN <= 1'h1;
        fast <= 1'h1;
        repeat (4500) @(posedge clock);
        cmpBit("dllLocked_r", 1'h1, dllLocked_r);
        hold <= 1'h1;
        repeat (12) @(posedge clock);
        cmpBit("dllLocked_r", 1'h0, dllLocked_r);
        stop_test();
    end
endmodule
